// [din_map_pkg.sv]
// constants shared by the digital input function mapper
package din_map_pkg;

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int NUM_IN = 6;

   localparam logic [7:0] OFS_FSEL_ONE   = 8'h00;
   localparam logic [7:0] OFS_FSEL_TWO   = 8'h04;
   localparam logic [7:0] OFS_FSEL_THREE = 8'h08;
   localparam logic [7:0] OFS_FSEL_FOUR  = 8'h0c;
   localparam logic [7:0] OFS_FSEL_FIVE  = 8'h10;
   localparam logic [7:0] OFS_FSEL_SIX   = 8'h14;
   localparam logic [7:0] OFS_STATUS     = 8'h18;
   localparam logic [7:0] OFS_CMD        = 8'h1c;

   // ----------------------------------------------------------------
   // reset values of the function selects
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_FSEL_ONE   = 8'h02;
   localparam logic [7:0] RST_FSEL_TWO   = 8'h03;
   localparam logic [7:0] RST_FSEL_THREE = 8'h00;
   localparam logic [7:0] RST_FSEL_FOUR  = 8'h00;
   localparam logic [7:0] RST_FSEL_FIVE  = 8'h00;
   localparam logic [7:0] RST_FSEL_SIX   = 8'h00;

   // ----------------------------------------------------------------
   // function codes
   // ----------------------------------------------------------------
   localparam logic [7:0] FN_NONE       = 8'h00;
   localparam logic [7:0] FN_RUN_STOP   = 8'h01;
   localparam logic [7:0] FN_START3     = 8'h02;
   localparam logic [7:0] FN_STOP3      = 8'h03;
   localparam logic [7:0] FN_ENABLE     = 8'h04;
   localparam logic [7:0] FN_SOURCE     = 8'h05;
   localparam logic [7:0] FN_INCH       = 8'h06;
   localparam logic [7:0] FN_DIRECTION  = 8'h07;
   localparam logic [7:0] FN_EXT_FAULT  = 8'h08;
   localparam logic [7:0] FN_EXT_ALARM  = 8'h09;
   localparam logic [7:0] FN_BRAKE      = 8'h0a;
   localparam logic [7:0] FN_FAULT_RST  = 8'h0b;
   localparam logic [7:0] FN_USER_LOAD  = 8'h0c;
   localparam logic [7:0] FN_EMERGENCY  = 8'h0e;
   localparam logic [7:0] FN_THERM_ALM  = 8'h0f;
   localparam logic [7:0] FN_THERM_FLT  = 8'h10;
   localparam logic [7:0] FN_MAX        = 8'h10;

   // ----------------------------------------------------------------
   // status and command fields
   // ----------------------------------------------------------------
   localparam int ST_LEVELS_LSB   = 0;
   localparam int ST_THERM_TRIP   = 8;
   localparam int ST_THERM_SHORT  = 9;
   localparam int ST_MOTOR_RUN    = 10;
   localparam int CMD_MOTOR_RUN   = 0;

   // ----------------------------------------------------------------
   // thermistor thresholds in ohms
   // ----------------------------------------------------------------
   localparam int OHM_W          = 16;
   localparam int THERM_TRIP_OHM = 3900;
   localparam int THERM_REL_OHM  = 1600;
   localparam int THERM_SHORT_OHM = 100;

   // ----------------------------------------------------------------
   // debounce timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ         = 100;
   localparam int DEBOUNCE_US     = 10;
   localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;

endpackage

// [din_debounce.sv]
// synchroniser and debouncer for one input level
`timescale 1ns/1ns
module din_debounce #(
   parameter int CYCLES = din_map_pkg::DEBOUNCE_CYCLES
) (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic pin,
   output logic      level_r
);
   import din_map_pkg::*;

   localparam int CW = $clog2(CYCLES + 1);

   logic [2:0]    sync_r;
   logic [CW-1:0] cnt_r;

   // ----------------------------------------------------------------
   // three stage synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync_r <= 3'h0;
      end else begin
         sync_r <= {sync_r[1:0], pin};
      end
   end

   // ----------------------------------------------------------------
   // level accepted only after it has stood for the whole window
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r   <= '0;
         level_r <= 1'b0;
      end else if (sync_r[2] != sync_r[1] || sync_r[2] == level_r) begin
         cnt_r <= '0;
      end else if (cnt_r == CW'(CYCLES - 1)) begin
         cnt_r   <= '0;
         level_r <= sync_r[2];
      end else begin
         cnt_r <= cnt_r + CW'(1);
      end
   end
endmodule

// [din_function_mapper.sv]
// digital input function mapper with its select registers
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module din_function_mapper #(
   parameter int DEBOUNCE = din_map_pkg::DEBOUNCE_CYCLES
) (
   input  wire logic                           clk_sys,
   input  wire logic                           rst_n,
   input  wire logic [din_map_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [din_map_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                           reg_wr,
   input  wire logic                           reg_rd,
   output logic      [din_map_pkg::DATA_W-1:0] reg_rdata,
   input  wire logic                           input_one,
   input  wire logic                           input_two,
   input  wire logic                           input_three,
   input  wire logic                           input_four,
   input  wire logic                           input_five,
   input  wire logic                           input_six,
   input  wire logic [din_map_pkg::OHM_W-1:0]  thermistor_ohms,
   input  wire logic                           motor_enabled,
   output logic                                run_request,
   output logic                                start_pulse,
   output logic                                stop_pulse,
   output logic                                general_enable,
   output logic                                command_source_select,
   output logic                                inching,
   output logic                                forward_contactor,
   output logic                                reverse_contactor,
   output logic                                external_fault,
   output logic                                external_alarm,
   output logic                                braking_permit,
   output logic                                fault_reset_pulse,
   output logic                                load_user_one,
   output logic                                load_user_two,
   output logic                                emergency_run,
   output logic                                thermistor_alarm,
   output logic                                thermistor_fault,
   output logic                                thermistor_short
);
   import din_map_pkg::*;


   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [7:0]        fsel_r [NUM_IN];
   logic [NUM_IN-1:0] pins;
   logic [NUM_IN-1:0] lvl;
   logic [NUM_IN-1:0] lvl_d_r;
   logic [NUM_IN-1:0] rise;
   logic [NUM_IN-1:0] fall;
   logic              therm_trip_r;
   logic              sw_run_r;

   assign pins = {input_six, input_five, input_four, input_three, input_two, input_one};

   // accepts a code only where it is defined for that input
   function automatic logic code_ok(input int idx, input logic [7:0] code);
      if (code > FN_MAX) begin
         return 1'b0;
      end else if (idx == 2) begin
         return code <= FN_USER_LOAD || code == FN_EMERGENCY;
      end else if (idx == 5) begin
         return code <= FN_USER_LOAD || code >= FN_THERM_ALM;
      end else begin
         return code <= FN_USER_LOAD;
      end
   endfunction

   function automatic logic [7:0] fsel_reset(input int idx);
      case (idx)
         0:       return RST_FSEL_ONE;
         1:       return RST_FSEL_TWO;
         2:       return RST_FSEL_THREE;
         3:       return RST_FSEL_FOUR;
         4:       return RST_FSEL_FIVE;
         default: return RST_FSEL_SIX;
      endcase
   endfunction

   function automatic logic [ADDR_W-1:0] fsel_ofs(input int idx);
      return ADDR_W'(OFS_FSEL_ONE + 8'(4 * idx));
   endfunction

   // ----------------------------------------------------------------
   // input conditioning
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NUM_IN; g++) begin : g_in
      din_debounce #(
         .CYCLES (DEBOUNCE)
      ) u_deb (
         .clk_sys (clk_sys),
         .rst_n   (rst_n),
         .pin     (pins[g]),
         .level_r (lvl[g])
      );
   end

   // an open pin reads 0, a closed one 1, including input six
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lvl_d_r <= '0;
      end else begin
         lvl_d_r <= lvl;
      end
   end

   assign rise = lvl & ~lvl_d_r;
   assign fall = ~lvl & lvl_d_r;

   // ----------------------------------------------------------------
   // function select registers
   // ----------------------------------------------------------------
   // rejected writes leave the old code, so reads never show a bad one
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_IN; i++) begin
            fsel_r[i] <= fsel_reset(i);
         end
      end else if (reg_wr && !motor_enabled && !sw_run_r) begin
         for (int i = 0; i < NUM_IN; i++) begin
            if (reg_addr == fsel_ofs(i) && code_ok(i, reg_wdata[7:0])) begin
               fsel_r[i] <= reg_wdata[7:0];
            end
         end
      end
   end

   // software run flag, read back at the command register
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sw_run_r <= 1'b0;
      end else if (reg_wr && reg_addr == OFS_CMD) begin
         sw_run_r <= reg_wdata[CMD_MOTOR_RUN];
      end
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= '0;
         for (int i = 0; i < NUM_IN; i++) begin
            if (reg_addr == fsel_ofs(i)) begin
               reg_rdata <= {24'h0, fsel_r[i]};
            end
         end
         if (reg_addr == OFS_STATUS) begin
            reg_rdata[ST_LEVELS_LSB +: NUM_IN] <= lvl;
            reg_rdata[ST_THERM_TRIP]           <= therm_trip_r;
            reg_rdata[ST_THERM_SHORT]          <= thermistor_short;
            reg_rdata[ST_MOTOR_RUN]            <= motor_enabled;
         end else if (reg_addr == OFS_CMD) begin
            reg_rdata[CMD_MOTOR_RUN] <= sw_run_r;
         end
      end else begin
         reg_rdata <= '0;
      end
   end

   // ----------------------------------------------------------------
   // thermistor detector on input six
   // ----------------------------------------------------------------
   // hysteresis: trip above the upper value, release only in the band
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         therm_trip_r     <= 1'b0;
         thermistor_short <= 1'b0;
      end else begin
         thermistor_short <= thermistor_ohms < OHM_W'(THERM_SHORT_OHM);
         if (thermistor_ohms > OHM_W'(THERM_TRIP_OHM)) begin
            therm_trip_r <= 1'b1;
         end else if (thermistor_ohms >= OHM_W'(THERM_SHORT_OHM) &&
                      thermistor_ohms <= OHM_W'(THERM_REL_OHM)) begin
            therm_trip_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         thermistor_alarm <= 1'b0;
         thermistor_fault <= 1'b0;
      end else begin
         thermistor_alarm <= fsel_r[5] == FN_THERM_ALM &&
                             (therm_trip_r || thermistor_short);
         thermistor_fault <= fsel_r[5] == FN_THERM_FLT &&
                             (therm_trip_r || thermistor_short);
      end
   end

   // ----------------------------------------------------------------
   // level functions
   // ----------------------------------------------------------------
   // absent functions default to their harmless state: enabled,
   // local, forward, no fault, no alarm, braking allowed
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         run_request           <= 1'b0;
         general_enable        <= 1'b1;
         command_source_select <= 1'b0;
         inching               <= 1'b0;
         forward_contactor     <= 1'b1;
         reverse_contactor     <= 1'b0;
         external_fault        <= 1'b0;
         external_alarm        <= 1'b0;
         braking_permit        <= 1'b1;
         emergency_run         <= 1'b0;
      end else begin
         logic rr;
         logic ge;
         logic src;
         logic inch;
         logic rev;
         logic ef;
         logic ea;
         logic br;
         rr   = 1'b0;
         ge   = 1'b1;
         src  = 1'b0;
         inch = 1'b0;
         rev  = 1'b0;
         ef   = 1'b0;
         ea   = 1'b0;
         br   = 1'b1;
         for (int i = 0; i < NUM_IN; i++) begin
            case (fsel_r[i])
               FN_RUN_STOP:  rr   = rr | lvl[i];
               FN_ENABLE:    ge   = ge & lvl[i];
               FN_SOURCE:    src  = src | lvl[i];
               FN_INCH:      inch = inch | lvl[i];
               FN_DIRECTION: rev  = rev | lvl[i];
               FN_EXT_FAULT: ef   = ef | ~lvl[i];
               FN_EXT_ALARM: ea   = ea | ~lvl[i];
               FN_BRAKE:     br   = br & lvl[i];
               default:      rr   = rr;
            endcase
         end
         run_request           <= rr;
         general_enable        <= ge;
         command_source_select <= src;
         inching               <= inch;
         forward_contactor     <= ~rev;
         reverse_contactor     <= rev;
         external_fault        <= ef;
         external_alarm        <= ea;
         braking_permit        <= br;
         emergency_run         <= fsel_r[2] == FN_EMERGENCY && lvl[2];
      end
   end

   // ----------------------------------------------------------------
   // edge functions
   // ----------------------------------------------------------------
   // one pulse per debounced edge, none for user loads while the motor is enabled; a held level never repeats
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         start_pulse       <= 1'b0;
         stop_pulse        <= 1'b0;
         fault_reset_pulse <= 1'b0;
         load_user_one     <= 1'b0;
         load_user_two     <= 1'b0;
      end else begin
         logic st;
         logic sp;
         logic fr;
         logic l1;
         logic l2;
         st = 1'b0;
         sp = 1'b0;
         fr = 1'b0;
         l1 = 1'b0;
         l2 = 1'b0;
         for (int i = 0; i < NUM_IN; i++) begin
            case (fsel_r[i])
               FN_START3:    st = st | rise[i];
               FN_STOP3:     sp = sp | fall[i];
               FN_FAULT_RST: fr = fr | rise[i];
               FN_USER_LOAD: begin
                  l1 = l1 | rise[i];
                  l2 = l2 | fall[i];
               end
               default:      st = st;
            endcase
         end
         start_pulse       <= st;
         stop_pulse        <= sp;
         fault_reset_pulse <= fr;
         load_user_one     <= l1 & ~motor_enabled;
         load_user_two     <= l2 & ~motor_enabled;
      end
   end
endmodule

// [din_map_chk.sv]
// assertion checker on the ports of the digital input function mapper
`timescale 1ns/1ns
module din_map_chk
   import din_map_pkg::*;
(
   input wire logic                           clk_sys,
   input wire logic                           rst_n,
   input wire logic                           reg_rd,
   input wire logic [din_map_pkg::DATA_W-1:0] reg_rdata,
   input wire logic                           motor_enabled,
   input wire logic [din_map_pkg::OHM_W-1:0]  thermistor_ohms,
   input wire logic                           start_pulse,
   input wire logic                           stop_pulse,
   input wire logic                           fault_reset_pulse,
   input wire logic                           forward_contactor,
   input wire logic                           reverse_contactor,
   input wire logic                           load_user_one,
   input wire logic                           load_user_two,
   input wire logic                           thermistor_alarm,
   input wire logic                           thermistor_fault,
   input wire logic                           thermistor_short
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data not zero outside read answer");
   start_single_a: assert property (start_pulse |=> !start_pulse)
      else $error("start pulse longer than one cycle");
   stop_single_a: assert property (stop_pulse |=> !stop_pulse)
      else $error("stop pulse longer than one cycle");
   reset_single_a: assert property (fault_reset_pulse |=> !fault_reset_pulse)
      else $error("fault reset repeated");
   contactor_excl_a: assert property (forward_contactor != reverse_contactor)
      else $error("contactors not complementary");
   // motor state is sampled a cycle late, so only a settled enable is judged
   load_blocked_a: assert property (motor_enabled && $past(motor_enabled) && $past(motor_enabled, 2)
      |-> !(load_user_one || load_user_two)) else $error("user load while motor enabled");
   load_excl_a: assert property (!(load_user_one && load_user_two))
      else $error("both user loads at once");
   short_set_a: assert property ((thermistor_ohms < 16'h0064) [*2] |=> thermistor_short)
      else $error("short not reported");
   short_clr_a: assert property ((thermistor_ohms >= 16'h0064) [*2] |=> !thermistor_short)
      else $error("short reported without short");
   therm_excl_a: assert property (!(thermistor_alarm && thermistor_fault))
      else $error("thermistor alarm and fault together");
endmodule
bind din_function_mapper din_map_chk din_map_chk_i (.clk_sys(clk_sys), .rst_n(rst_n),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .motor_enabled(motor_enabled),
   .thermistor_ohms(thermistor_ohms), .start_pulse(start_pulse), .stop_pulse(stop_pulse),
   .fault_reset_pulse(fault_reset_pulse), .forward_contactor(forward_contactor),
   .reverse_contactor(reverse_contactor), .load_user_one(load_user_one),
   .load_user_two(load_user_two), .thermistor_alarm(thermistor_alarm),
   .thermistor_fault(thermistor_fault), .thermistor_short(thermistor_short));

// [din_field_model.sv]
// field contacts with chatter and a motor thermistor
`timescale 1ns/1ns
module din_field_model (
   input  wire logic        clk_sys,
   input  wire logic [5:0]  contact_want,
   input  wire logic [15:0] ohms_want,
   output logic      [5:0]  contact,
   output logic      [15:0] ohms
);
   logic [5:0] settled_r;
   logic [1:0] bounce_r;
   initial begin
      settled_r = '0;
      bounce_r  = '0;
      contact   = '0;
      ohms      = 16'h03e8;
   end
   // open pair reads 0, shorted pair reads 1
   always @(posedge clk_sys) begin
      ohms <= ohms_want;
      // one-cycle chatter, shorter than the debounce window
      if (bounce_r == 2'h0 && contact_want != settled_r) begin
         bounce_r <= 2'h2;
         contact  <= contact_want;
      end else if (bounce_r == 2'h2) begin
         bounce_r <= 2'h1;
         contact  <= settled_r;
      end else if (bounce_r == 2'h1) begin
         bounce_r  <= 2'h0;
         contact   <= contact_want;
         settled_r <= contact_want;
      end
   end
endmodule

// [digital_input_function_mapper_tb.sv]
// self-checking testbench of the digital input function mapper
`timescale 1ns/1ns
module digital_input_function_mapper_tb;
   import din_map_pkg::*;
   localparam int DB = 4;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        motor_enabled = 1'b0;
   logic [5:0]  want = '0;
   logic [15:0] ohms_want = 16'h03e8;
   logic [31:0] reg_rdata, seed = 32'h0000cfb8;
   logic [5:0]  contact;
   logic [15:0] ohms, oh[5];
   logic        run_request, start_pulse, stop_pulse, general_enable, command_source_select;
   logic        inching, forward_contactor, reverse_contactor, external_fault, external_alarm;
   logic        braking_permit, fault_reset_pulse, load_user_one, load_user_two, emergency_run;
   logic        thermistor_alarm, thermistor_fault, thermistor_short;
   logic [9:0]  lv;
   logic [4:0]  pv;
   int          fail_count = 0, checked = 0, cnt[5] = '{default: 0}, k;
   din_function_mapper #(.DEBOUNCE(DB)) din_function_mapper_i (.clk_sys(clk_sys), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .input_one(contact[0]), .input_two(contact[1]),
      .input_three(contact[2]), .input_four(contact[3]), .input_five(contact[4]),
      .input_six(contact[5]), .thermistor_ohms(ohms), .motor_enabled(motor_enabled),
      .run_request(run_request), .start_pulse(start_pulse), .stop_pulse(stop_pulse),
      .general_enable(general_enable), .command_source_select(command_source_select),
      .inching(inching), .forward_contactor(forward_contactor),
      .reverse_contactor(reverse_contactor), .external_fault(external_fault),
      .external_alarm(external_alarm), .braking_permit(braking_permit),
      .fault_reset_pulse(fault_reset_pulse), .load_user_one(load_user_one),
      .load_user_two(load_user_two), .emergency_run(emergency_run),
      .thermistor_alarm(thermistor_alarm), .thermistor_fault(thermistor_fault),
      .thermistor_short(thermistor_short));
   din_field_model din_field_model_i (.clk_sys(clk_sys), .contact_want(want),
      .ohms_want(ohms_want), .contact(contact), .ohms(ohms));
   assign lv = {run_request, general_enable, command_source_select, inching, forward_contactor,
                reverse_contactor, external_fault, external_alarm, braking_permit, emergency_run};
   assign pv = {load_user_two, load_user_one, fault_reset_pulse, stop_pulse, start_pulse};
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      foreach (cnt[i]) if (pv[i] === 1'b1) cnt[i]++;
   end
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // absent functions leave enable, forward and braking on
   function automatic logic [31:0] exp_lv(input int c, input logic p);
      logic [31:0] v;
      v = 32'h122;
      case (c)
         1: v[9] = p;
         4: v[8] = p;
         5: v[7] = p;
         6: v[6] = p;
         7: v[5:4] = {!p, p};
         8: v[3] = !p;
         9: v[2] = !p;
         10: v[1] = p;
         14: v[0] = p;
         default: ;
      endcase
      return v;
   endfunction
   function automatic logic [31:0] exp_pc(input int c);
      return (c == 2) ? 32'h1 : (c == 3) ? 32'h10 : (c == 11) ? 32'h100 :
             (c == 12) ? 32'h11000 : 32'h0;
   endfunction
   function automatic logic [31:0] cnt_word();
      logic [31:0] w;
      w = '0;
      foreach (cnt[i]) w[4*i+:4] = cnt[i][3:0];
      return w;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", e, reg_rdata);
   endtask
   task automatic press(input int b, input logic p);
      @(posedge clk_sys);
      want[b] <= p;
      repeat (16 + xs() % 8) @(posedge clk_sys);
      #1;
   endtask
   task automatic report_and_stop();
      $display("Comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #900000;
      fail_count++;
      report_and_stop();
   end
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int i = 0; i < 6; i++) rd(8'(4 * i), (i == 0) ? 32'h2 : (i == 1) ? 32'h3 : 32'h0);
      rd(8'h20, 32'h0);
      $display("Test reset_values done");
      press(0, 1'b1);
      press(0, 1'b0);
      press(1, 1'b1);
      press(1, 1'b0);
      chk("start_stop_pulses", 32'h11, cnt_word());
      $display("Test three_wire done");
      for (int c = 0; c <= 14; c++) begin
         if (c == 13) continue;
         k = (c == 14) ? 2 : 3 + xs() % 3;
         wr(8'(4 * k), 32'(c));
         rd(8'(4 * k), 32'(c));
         chk("levels_open", exp_lv(c, 1'b0), {22'h0, lv});
         cnt = '{default: 0};
         press(k, 1'b1);
         chk("levels_closed", exp_lv(c, 1'b1), {22'h0, lv});
         rd(OFS_STATUS, 32'h1 << k);
         press(k, 1'b0);
         chk("levels_reopened", exp_lv(c, 1'b0), {22'h0, lv});
         chk("pulses", exp_pc(c), cnt_word());
         wr(8'(4 * k), 32'h0);
      end
      $display("Test function_codes done");
      for (int c = 13; c <= 17; c++) begin
         wr(OFS_FSEL_FOUR, 32'(c));
         rd(OFS_FSEL_FOUR, 32'h0);
         wr(OFS_FSEL_THREE, 32'(c));
         rd(OFS_FSEL_THREE, (c == 14) ? 32'he : 32'h0);
         wr(OFS_FSEL_THREE, 32'h0);
      end
      $display("Test reserved_codes done");
      wr(OFS_FSEL_FOUR, 32'hc);
      @(posedge clk_sys);
      motor_enabled <= 1'b1;
      wr(OFS_FSEL_FOUR, 32'h1);
      rd(OFS_FSEL_FOUR, 32'hc);
      rd(OFS_STATUS, 32'h400);
      cnt = '{default: 0};
      press(3, 1'b1);
      press(3, 1'b0);
      chk("blocked_loads", 32'h0, cnt_word());
      @(posedge clk_sys);
      motor_enabled <= 1'b0;
      wr(OFS_CMD, 32'h1);
      rd(OFS_CMD, 32'h1);
      wr(OFS_FSEL_FIVE, 32'h1);
      rd(OFS_FSEL_FIVE, 32'h0);
      wr(OFS_CMD, 32'h0);
      wr(OFS_FSEL_FIVE, 32'h1);
      rd(OFS_FSEL_FIVE, 32'h1);
      wr(OFS_FSEL_FIVE, 32'h0);
      $display("Test motor_running done");
      oh = '{16'h0fa0, 16'h07d0, 16'h03e8 + 16'(xs() % 600), 16'h0032, 16'h03e8};
      for (int c = 15; c <= 16; c++) begin
         wr(OFS_FSEL_SIX, 32'(c));
         foreach (oh[j]) begin
            @(posedge clk_sys);
            ohms_want <= oh[j];
            repeat (6) @(posedge clk_sys);
            #1;
            chk("thermistor", (5'b01011 >> j) & 1 ? ((c == 16) ? 32'h4 : 32'h2) | (j == 3) : 32'h0,
                {29'h0, thermistor_fault, thermistor_alarm, thermistor_short});
         end
      end
      $display("Test thermistor done");
      report_and_stop();
   end
endmodule
